/* wfd_wake_detector.sv */
// Contract
// - Sleep state plus a wake enable enters wake mode; normal reception stops.
// - Wake mode watches pattern frames, magic frames and link status changes.
// - Four filters; wake frame needs CRC match, plus address filter pass where the filter's address-match bit is set.
// - Filter check is CRC-16 x16+x15+x2+1 over mask-selected bytes only.
// - 32-bit mask covers 32 bytes from offset; bit j selects byte offset+j.
// - Programmed offset field times two gives the real start byte.
// - Byte at offset plus highest mask bit must equal the last-byte value.
// - Filters work independently or cascaded as a chain.
// - Each byte write enters bits 31:24 and shifts older bytes down.
// - Filter 0 byte mask loads through offset 01h on page 3.
// - Offset 05h holds filter 1 CRC high half, filter 0 CRC low half.
// - Offset 07h holds four offset bytes, filter 0 lowest.
// - Offset 08h holds four last-byte values, filter 0 lowest.
// - Offset 09h holds enable, address match and cascade; 03h enables filter 0.
// - Magic frame: all-ones sync then sixteen back-to-back station addresses.
`timescale 1ns/10ps
module wfd_wake_detector (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] reg_page,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [47:0] station_addr,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  input wire logic rx_eof,
  input wire logic rx_addr_ok,
  input wire logic rx_fcs_ok,
  input wire logic link_up,
  output logic rx_enable,
  output logic wake_mode,
  output logic wake_event_pin
);

  // ********************************************************
  // Register port decode
  // ********************************************************
  function automatic logic wfd_hit(input logic [1:0] pg, input logic [4:0] a,
                                   input logic [4:0] ofs);
    return (pg == wfd_pkg::WFD_PAGE_WAKE) && (a == ofs);
  endfunction : wfd_hit

  logic [31:0] words_q [1:9];
  logic [2:0] en_q;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic sleep_q;
  logic pin_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  wire wr_wake_control_status = reg_wr && wfd_hit(reg_page, reg_addr, wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS);
  wire wr_pmr = reg_wr && wfd_hit(reg_page, reg_addr, wfd_pkg::WFD_OFS_PMR);

  // Shift-loaded 32-bit words at offsets 01h..09h
  genvar gk;
  generate
    for (gk = 1; gk <= 9; gk++) begin : g_word
      wire wr_word = reg_wr && wfd_hit(reg_page, reg_addr, 5'(gk));
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          words_q[gk] <= wfd_pkg::WFD_WORD_RST;
        end else if (wr_word) begin
          words_q[gk] <= {reg_wdata, words_q[gk][31:8]};
        end
      end
    end
  endgenerate

  wire [31:0] cmd_w = words_q[wfd_pkg::WFD_OFS_CMD];
  wire cascade = cmd_w[wfd_pkg::WFD_CMD_CASCADE];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_q <= wfd_pkg::WFD_EN_RST;
      sleep_q <= wfd_pkg::WFD_SLEEP_RST;
    end else begin
      if (wr_wake_control_status) begin
        en_q <= reg_wdata[2:0];
      end
      if (wr_pmr) begin
        sleep_q <= reg_wdata[wfd_pkg::WFD_PMR_SLEEP];
      end
    end
  end

  // Wake mode gates off normal reception
  assign wake_mode = sleep_q && (en_q != 3'h0);
  assign rx_enable = !wake_mode;

  // ********************************************************
  // Frame byte position
  // ********************************************************
  logic [10:0] pos_q;
  wire [10:0] pos = rx_sof ? 11'h000 : pos_q;
  wire rx_byte = rx_valid && wake_mode;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos_q <= 11'h000;
    end else if (rx_byte) begin
      pos_q <= (pos == wfd_pkg::WFD_POS_MAX) ? pos : pos + 11'h001;
    end
  end

  // ********************************************************
  // Pattern filters
  // ********************************************************
  function automatic logic [4:0] wfd_top_bit(input logic [31:0] m);
    logic [4:0] t;
    t = 5'h00;
    for (int k = 0; k < 32; k++) begin
      if (m[k]) begin
        t = 5'(k);
      end
    end
    return t;
  endfunction : wfd_top_bit

  logic [3:0] f_en;
  logic [3:0] f_match;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      wfd_crc_if u_if ();
      wfd_crc16 u_crc (
        .clock(clock),
        .nrst(nrst),
        .port(u_if.engine)
      );
      wire [31:0] mask = words_q[wfd_pkg::WFD_OFS_MASK0 + gi];
      wire [15:0] exp_crc = words_q[wfd_pkg::WFD_OFS_CRC10 + gi / 2][16 * (gi % 2) +: 16];
      wire [7:0] ofs = words_q[wfd_pkg::WFD_OFS_OFST][8 * gi +: 8];
      wire [7:0] last = words_q[wfd_pkg::WFD_OFS_LAST][8 * gi +: 8];
      wire [3:0] cmd = cmd_w[wfd_pkg::WFD_CMD_NIB * gi +: 4];
      wire [10:0] start = {2'b00, ofs, 1'b0};
      wire [10:0] rel = pos - start;
      wire in_win = (pos >= start) && (rel < wfd_pkg::WFD_WIN_LEN);
      wire sel = in_win && mask[rel[4:0]];
      wire last_hit = sel && (rel[4:0] == wfd_top_bit(mask));
      logic lb_ok_q;
      assign u_if.clear = rx_byte && rx_sof;
      assign u_if.update = rx_byte && sel;
      assign u_if.data = rx_data;
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          lb_ok_q <= 1'b0;
        end else if (rx_byte && last_hit) begin
          lb_ok_q <= (rx_data == last);
        end else if (rx_byte && rx_sof) begin
          lb_ok_q <= 1'b0;
        end
      end
      assign f_en[gi] = cmd[wfd_pkg::WFD_CMD_EN];
      assign f_match[gi] = f_en[gi] && (u_if.crc == exp_crc) && lb_ok_q
                           && (!cmd[wfd_pkg::WFD_CMD_DA] || rx_addr_ok);
    end
  endgenerate

  // Cascade needs every enabled filter to pass in chain
  wire hit_indep = |f_match;
  wire hit_chain = (f_en != 4'h0) && ((f_match | ~f_en) == 4'hF);
  wire frame_hit = cascade ? hit_chain : hit_indep;
  wire frame_end = rx_eof && rx_fcs_ok && wake_mode;
  wire frame_evt = frame_end && en_q[wfd_pkg::WFD_WAKE_CONTROL_STATUS_FRAME_EN] && frame_hit;

  // ********************************************************
  // Magic frame search
  // ********************************************************
  wfd_pkg::wfd_magic_t mg_state_q;
  wfd_pkg::wfd_magic_t mg_state_d;
  logic [2:0] mg_ff_q;
  logic [2:0] mg_ff_d;
  logic [6:0] mg_idx_q;
  logic [6:0] mg_idx_d;
  logic [2:0] mg_mac_q;
  logic [2:0] mg_mac_d;
  logic mg_found_q;
  logic mg_found_d;
  wire wfd_pkg::wfd_magic_t mg_state = rx_sof ? wfd_pkg::WFD_MG_HUNT : mg_state_q;
  wire [2:0] mg_ff = rx_sof ? 3'h0 : mg_ff_q;
  wire [2:0] mg_mac = (mg_state == wfd_pkg::WFD_MG_HUNT) ? 3'h0 : mg_mac_q;
  wire [7:0] mac_byte = station_addr[{mg_mac, 3'b000} +: 8];
  wire is_sync = rx_data == wfd_pkg::WFD_SYNC_BYTE;
  wire mac_eq = rx_data == mac_byte;
  wire [2:0] ff_inc = (mg_ff == wfd_pkg::WFD_SYNC_LEN) ? mg_ff : mg_ff + 3'h1;

  always_comb begin
    mg_state_d = mg_state_q;
    mg_ff_d = mg_ff_q;
    mg_idx_d = mg_idx_q;
    mg_mac_d = mg_mac_q;
    mg_found_d = rx_byte && rx_sof ? 1'b0 : mg_found_q;
    if (rx_byte) begin
      case (mg_state)
        wfd_pkg::WFD_MG_HUNT: begin
          if ((mg_ff == wfd_pkg::WFD_SYNC_LEN) && mac_eq) begin
            mg_state_d = wfd_pkg::WFD_MG_MATCH;
            mg_idx_d = 7'h01;
            mg_mac_d = 3'h1;
          end else begin
            mg_ff_d = is_sync ? ff_inc : 3'h0;
          end
        end
        wfd_pkg::WFD_MG_MATCH: begin
          if (mac_eq) begin
            mg_mac_d = (mg_mac == wfd_pkg::WFD_MAC_LAST) ? 3'h0 : mg_mac + 3'h1;
            mg_idx_d = mg_idx_q + 7'h01;
            if (mg_idx_q + 7'h01 == wfd_pkg::WFD_MAGIC_BYTES) begin
              mg_found_d = 1'b1;
              mg_state_d = wfd_pkg::WFD_MG_HUNT;
              mg_ff_d = 3'h0;
            end
          end else begin
            mg_state_d = wfd_pkg::WFD_MG_HUNT;
            mg_ff_d = is_sync ? 3'h1 : 3'h0;
          end
        end
        default: begin
          mg_state_d = wfd_pkg::WFD_MG_HUNT;
          mg_ff_d = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mg_state_q <= wfd_pkg::WFD_MG_HUNT;
      mg_ff_q <= 3'h0;
      mg_idx_q <= 7'h00;
      mg_mac_q <= 3'h0;
      mg_found_q <= 1'b0;
    end else begin
      mg_state_q <= mg_state_d;
      mg_ff_q <= mg_ff_d;
      mg_idx_q <= mg_idx_d;
      mg_mac_q <= mg_mac_d;
      mg_found_q <= mg_found_d;
    end
  end

  wire magic_evt = frame_end && en_q[wfd_pkg::WFD_WAKE_CONTROL_STATUS_MAGIC_EN] && mg_found_q;

  // ********************************************************
  // Link status change
  // ********************************************************
  logic link_s1_q;
  logic link_s2_q;
  logic link_s3_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link_s1_q <= 1'b0;
      link_s2_q <= 1'b0;
      link_s3_q <= 1'b0;
    end else begin
      link_s1_q <= link_up;
      link_s2_q <= link_s1_q;
      link_s3_q <= link_s2_q;
    end
  end

  wire link_evt = wake_mode && en_q[wfd_pkg::WFD_WAKE_CONTROL_STATUS_LINK_EN]
                  && (link_s2_q != link_s3_q);

  // ********************************************************
  // Status, wake pin and read back
  // ********************************************************
  wire [2:0] evt = {frame_evt, magic_evt, link_evt};
  wire [2:0] clr = wr_wake_control_status ? reg_wdata[wfd_pkg::WFD_WAKE_CONTROL_STATUS_FRAME_ST:wfd_pkg::WFD_WAKE_CONTROL_STATUS_LINK_ST]
                           : 3'h0;
  assign stat_d = evt | (stat_q & ~clr);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stat_q <= wfd_pkg::WFD_STAT_RST;
      pin_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      stat_q <= stat_d;
      pin_q <= stat_d != 3'h0;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  wire [7:0] wake_control_status_rd = {1'b0, stat_q, 1'b0, en_q};

  always_comb begin
    rd_mux = 8'h00;
    if (reg_page == wfd_pkg::WFD_PAGE_WAKE) begin
      if (reg_addr >= wfd_pkg::WFD_OFS_MASK0 && reg_addr <= wfd_pkg::WFD_OFS_CMD) begin
        rd_mux = words_q[reg_addr - wfd_pkg::WFD_OFS_MASK0 + 5'h01][7:0];
      end else if (reg_addr == wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS) begin
        rd_mux = wake_control_status_rd;
      end else if (reg_addr == wfd_pkg::WFD_OFS_PMR) begin
        rd_mux = {7'h00, sleep_q};
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign wake_event_pin = pin_q;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_mask0_write;
    reg_wr && wfd_hit(reg_page, reg_addr, wfd_pkg::WFD_OFS_MASK0);
  endsequence
  sequence s_frame_done;
    rx_eof && rx_fcs_ok && wake_mode;
  endsequence

  a_rx_gated_sleep: assert property (wr_pmr && reg_wdata[wfd_pkg::WFD_PMR_SLEEP]
    && en_q != 3'h0 && !wr_wake_control_status |=> wake_mode && !rx_enable)
    else $error("reception not stopped in wake mode");
  a_mask_shift_load: assert property (s_mask0_write |=>
    words_q[1] == {$past(reg_wdata), $past(words_q[1][31:8])})
    else $error("mask byte not shifted in at the top");
  a_frame_event_set: assert property (s_frame_done ##0 en_q[1] && frame_hit
    |=> stat_q[2] ##1 wake_event_pin)
    else $error("frame wake not recorded");
  a_frame_needs_filter: assert property (s_frame_done ##0 !frame_hit && !stat_q[2]
    && !reg_wr |=> !stat_q[2])
    else $error("frame wake without an enabled filter");
  a_cascade_all_pass: assert property (cascade && frame_evt |->
    (f_match | ~f_en) == 4'hF)
    else $error("cascade wake with a failing filter");
  a_magic_event_set: assert property (s_frame_done ##0 en_q[2] && mg_found_q
    |=> stat_q[1])
    else $error("magic wake not recorded");
  a_link_event_set: assert property (wake_mode && en_q[0] && $changed(link_s2_q)
    |=> stat_q[0] ##1 wake_event_pin)
    else $error("link change not recorded");
  a_status_sticky: assert property (stat_q[0] && !wr_wake_control_status |=> stat_q[0])
    else $error("status bit lost without clear");
  a_pin_tracks_stat: assert property (stat_q != 3'h0 && !wr_wake_control_status |-> ##1 wake_event_pin)
    else $error("wake pin low with status pending");

endmodule : wfd_wake_detector

/* wfd_pkg.sv */
package wfd_pkg;

  // ********************************************************
  // Register page and offsets
  // ********************************************************
  localparam logic [1:0] WFD_PAGE_WAKE = 2'h3;
  localparam logic [4:0] WFD_OFS_MASK0 = 5'h01;
  localparam logic [4:0] WFD_OFS_MASK1 = 5'h02;
  localparam logic [4:0] WFD_OFS_MASK2 = 5'h03;
  localparam logic [4:0] WFD_OFS_MASK3 = 5'h04;
  localparam logic [4:0] WFD_OFS_CRC10 = 5'h05;
  localparam logic [4:0] WFD_OFS_CRC32 = 5'h06;
  localparam logic [4:0] WFD_OFS_OFST = 5'h07;
  localparam logic [4:0] WFD_OFS_LAST = 5'h08;
  localparam logic [4:0] WFD_OFS_CMD = 5'h09;
  localparam logic [4:0] WFD_OFS_WAKE_CONTROL_STATUS = 5'h0A;
  localparam logic [4:0] WFD_OFS_PMR = 5'h0B;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int WFD_WAKE_CONTROL_STATUS_LINK_EN = 0;
  localparam int WFD_WAKE_CONTROL_STATUS_FRAME_EN = 1;
  localparam int WFD_WAKE_CONTROL_STATUS_MAGIC_EN = 2;
  localparam int WFD_WAKE_CONTROL_STATUS_LINK_ST = 4;
  localparam int WFD_WAKE_CONTROL_STATUS_MAGIC_ST = 5;
  localparam int WFD_WAKE_CONTROL_STATUS_FRAME_ST = 6;
  localparam int WFD_PMR_SLEEP = 0;
  localparam int WFD_CMD_EN = 0;
  localparam int WFD_CMD_DA = 1;
  localparam int WFD_CMD_NIB = 4;
  localparam int WFD_CMD_CASCADE = 16;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [31:0] WFD_WORD_RST = 32'h0000_0000;
  localparam logic [2:0] WFD_EN_RST = 3'h0;
  localparam logic [2:0] WFD_STAT_RST = 3'h0;
  localparam logic WFD_SLEEP_RST = 1'b0;

  // ********************************************************
  // Checks and counts
  // ********************************************************
  localparam logic [15:0] WFD_CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] WFD_CRC_INIT = 16'hFFFF;
  localparam logic [10:0] WFD_WIN_LEN = 11'h020;
  localparam logic [10:0] WFD_POS_MAX = 11'h7FF;
  localparam logic [7:0] WFD_SYNC_BYTE = 8'hFF;
  localparam logic [2:0] WFD_SYNC_LEN = 3'h6;
  localparam logic [2:0] WFD_MAC_LAST = 3'h5;
  localparam logic [6:0] WFD_MAGIC_BYTES = 7'h60;

  typedef enum logic {WFD_MG_HUNT, WFD_MG_MATCH} wfd_magic_t;

endpackage : wfd_pkg

/* wfd_crc_if.sv */
`timescale 1ns/10ps
interface wfd_crc_if;
  logic clear;
  logic update;
  logic [7:0] data;
  logic [15:0] crc;
  modport user (output clear, output update, output data, input crc);
  modport engine (input clear, input update, input data, output crc);
endinterface : wfd_crc_if

/* wfd_crc16.sv */
`timescale 1ns/10ps
module wfd_crc16 (
  input wire logic clock,
  input wire logic nrst,
  wfd_crc_if.engine port
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic [15:0] base;

  // ********************************************************
  // Byte step, LSB first, reflected x16+x15+x2+1
  // ********************************************************
  function automatic logic [15:0] wfd_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      if (r[0] ^ b[k]) begin
        r = (r >> 1) ^ wfd_pkg::WFD_CRC_POLY_REFL;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : wfd_step

  assign base = port.clear ? wfd_pkg::WFD_CRC_INIT : crc_q;
  assign crc_d = port.update ? wfd_step(base, port.data) : base;
  assign port.crc = crc_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      crc_q <= wfd_pkg::WFD_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

endmodule : wfd_crc16

/* wfd_rx_source.sv */
`timescale 1ns/10ps
module wfd_rx_source (
  input wire logic clock,
  output logic rx_valid,
  output logic rx_sof,
  output logic [7:0] rx_data,
  output logic rx_eof,
  output logic rx_addr_ok,
  output logic rx_fcs_ok
);
  logic [7:0] frame [0:127];

  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = 8'hA5;
    rx_eof = 1'b0;
    rx_addr_ok = 1'b0;
    rx_fcs_ok = 1'b0;
  end

  // ********************************************************
  // One frame: sof byte, back-to-back bytes, eof pulse
  // ********************************************************
  task automatic send(input int len, input logic aok, input logic fok);
    for (int i = 0; i < len; i++) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_sof = (i == 0);
      rx_data = frame[i];
    end
    @(negedge clock);
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = ~rx_data;
    rx_eof = 1'b1;
    rx_addr_ok = aok;
    rx_fcs_ok = fok;
    @(negedge clock);
    // Qualifiers go stale once sampled
    rx_eof = 1'b0;
    rx_addr_ok = ~aok;
    rx_fcs_ok = ~fok;
    rx_data = ~rx_data;
  endtask : send
endmodule : wfd_rx_source

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  localparam logic [279:0] PING =
    280'h00A00CC47D69_000EC6123456_0800_4500003C018C0000_8001271E_C009C902_C009C901_08;
  localparam logic [47:0] STATION = 48'h55_44_33_22_11_00;
  logic clock, nrst, reg_wr, reg_rd, link_up;
  logic [1:0] reg_page;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_data;
  logic rx_valid, rx_sof, rx_eof, rx_addr_ok, rx_fcs_ok;
  logic rx_enable, wake_mode, wake_event_pin;
  logic [15:0] crc0;
  int fail_count, compares, cycles;

  wfd_rx_source src (.clock(clock), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data),
    .rx_eof(rx_eof), .rx_addr_ok(rx_addr_ok), .rx_fcs_ok(rx_fcs_ok));

  wfd_wake_detector uut (.clock(clock), .nrst(nrst), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .station_addr(STATION), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data), .rx_eof(rx_eof), .rx_addr_ok(rx_addr_ok), .rx_fcs_ok(rx_fcs_ok),
    .link_up(link_up), .rx_enable(rx_enable), .wake_mode(wake_mode),
    .wake_event_pin(wake_event_pin));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ********************************************************
  // Register access and comparison
  // ********************************************************
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr

  task automatic wr32(input logic [4:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) wr(a, w[8*i +: 8]);
  endtask : wr32

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rdata & m, exp);
  endtask : rd_chk

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ********************************************************
  // Frames and expected check values
  // ********************************************************
  task automatic load_ping;
    for (int i = 0; i < 128; i++) src.frame[i] = (i < 35) ? PING[8*(34-i) +: 8] : 8'h5A;
  endtask : load_ping

  task automatic load_magic(input int reps);
    for (int i = 0; i < 128; i++) src.frame[i] = (i >= 4 && i < 10) ? 8'hFF : 8'h12;
    for (int r = 0; r < reps; r++)
      for (int b = 0; b < 6; b++) src.frame[10 + 6*r + b] = STATION[8*b +: 8];
  endtask : load_magic

  function automatic logic [15:0] crc_of(input logic [31:0] m, input int ofs);
    logic [15:0] c;
    c = wfd_pkg::WFD_CRC_INIT;
    for (int j = 0; j < 32; j++) begin
      if (m[j]) begin
        c = c ^ {8'h00, src.frame[ofs + j]};
        for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ wfd_pkg::WFD_CRC_POLY_REFL) : (c >> 1);
      end
    end
    return c;
  endfunction : crc_of

  task automatic frame_case(input int idx, input logic [7:0] v, input logic aok,
                            input logic [7:0] exp);
    load_ping();
    if (idx >= 0) src.frame[idx] = v;
    src.send(40, aok, 1'b1);
    repeat (2) @(negedge clock);
    chk({7'h00, wake_event_pin}, {7'h00, exp != 8'h00});
    rd_chk(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h70, exp);
    // Clear status but keep frame enable, else wake mode drops
    wr(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h72);
  endtask : frame_case

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    nrst = 1'b0;
    reg_page = wfd_pkg::WFD_PAGE_WAKE;
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    link_up = 1'b1;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    chk({5'h00, rx_enable, wake_mode, wake_event_pin}, 8'h04);
    rd_chk(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'hFF, 8'h00);
    load_ping();
    crc0 = crc_of(32'h00400807, 12);
    wr32(wfd_pkg::WFD_OFS_MASK0, 32'h00400807);
    rd_chk(wfd_pkg::WFD_OFS_MASK0, 8'hFF, 8'h07);
    wr32(wfd_pkg::WFD_OFS_CRC10, {16'h0000, crc0});
    rd_chk(wfd_pkg::WFD_OFS_CRC10, 8'hFF, crc0[7:0]);
    wr32(wfd_pkg::WFD_OFS_OFST, 32'h00000006);
    rd_chk(wfd_pkg::WFD_OFS_OFST, 8'hFF, 8'h06);
    wr32(wfd_pkg::WFD_OFS_LAST, 32'h00000008);
    rd_chk(wfd_pkg::WFD_OFS_LAST, 8'hFF, 8'h08);
    wr32(wfd_pkg::WFD_OFS_CMD, 32'h00000003);
    rd_chk(wfd_pkg::WFD_OFS_CMD, 8'hFF, 8'h03);
    reg_page = 2'h0;
    wr(wfd_pkg::WFD_OFS_MASK0, 8'hFF);
    reg_page = wfd_pkg::WFD_PAGE_WAKE;
    rd_chk(wfd_pkg::WFD_OFS_MASK0, 8'hFF, 8'h07);
    rd_chk(5'h1F, 8'hFF, 8'h00);
    frame_case(-1, 8'h00, 1'b1, 8'h00);
    wr(5'h15, 8'h00);
    wr(wfd_pkg::WFD_OFS_PMR, 8'h01);
    wr(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h02);
    chk({6'h00, rx_enable, wake_mode}, 8'h01);
    frame_case(-1, 8'h00, 1'b1, 8'h40);
    frame_case(34, 8'h09, 1'b1, 8'h00);
    frame_case(14, 8'h46, 1'b1, 8'h00);
    frame_case(15, 8'h77, 1'b1, 8'h40);
    frame_case(-1, 8'h00, 1'b0, 8'h00);
    wr32(wfd_pkg::WFD_OFS_CMD, 32'h00010013);
    frame_case(-1, 8'h00, 1'b1, 8'h00);
    wr32(wfd_pkg::WFD_OFS_CMD, 32'h00010003);
    frame_case(-1, 8'h00, 1'b1, 8'h40);
    wr32(wfd_pkg::WFD_OFS_CMD, 32'h00000013);
    frame_case(-1, 8'h00, 1'b1, 8'h40);
    wr(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h04);
    load_magic(16);
    src.send(110, 1'b1, 1'b1);
    repeat (2) @(negedge clock);
    rd_chk(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h70, 8'h20);
    wr(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h74);
    load_magic(15);
    src.send(110, 1'b1, 1'b1);
    repeat (2) @(negedge clock);
    rd_chk(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h70, 8'h00);
    wr(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h01);
    link_up = 1'b0;
    repeat (8) @(negedge clock);
    chk({7'h00, wake_event_pin}, 8'h01);
    rd_chk(wfd_pkg::WFD_OFS_WAKE_CONTROL_STATUS, 8'h70, 8'h10);
    tally_and_finish();
  end
endmodule : tb_top
